// ---- p6mux_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the pin 6 output mux
`ifndef P6MUX_CFG_SVH
`define P6MUX_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define P6M_IDX_OUT_CTL 8'h16
`define P6M_IDX_PORT_CFG 8'h30
`define P6M_IDX_STATUS 8'h31
`define P6M_ADDR_W 10

// ****************************************************************
// Output control field positions
// ****************************************************************
`define P6M_EN_BIT 0
`define P6M_VAL_BIT 1
`define P6M_SRC_LO 2
`define P6M_SRC_HI 4
`define P6M_SEL_LO 5
`define P6M_SEL_HI 7

// ****************************************************************
// Port configuration field positions
// ****************************************************************
`define P6M_PEN_LO 0
`define P6M_PEN_HI 3
`define P6M_TXS_LO 4
`define P6M_TXS_HI 7

// ****************************************************************
// Reset values
// ****************************************************************
`define P6M_OUT_CTL_RST 8'h00
`define P6M_PORT_CFG_RST 8'hff

// ****************************************************************
// Timing: cycles from setup edge to pready high
// ****************************************************************
`define P6M_APB_WAIT 1

`endif

// ---- p6mux_pkg.sv ----
// Types shared by the pin 6 output mux
package p6mux_pkg;

    // Source group codes
    typedef enum logic [2:0] {
        P6M_SRC_RX0 = 3'h0,
        P6M_SRC_RX1 = 3'h1,
        P6M_SRC_RX2 = 3'h2,
        P6M_SRC_RX3 = 3'h3,
        P6M_SRC_DEV = 3'h4,
        P6M_SRC_RSV5 = 3'h5,
        P6M_SRC_TX0 = 3'h6,
        P6M_SRC_RSV7 = 3'h7
    } p6m_src_t;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        P6M_BUS_IDLE = 2'b01,
        P6M_BUS_ANSWER = 2'b10
    } p6m_bus_t;

endpackage : p6mux_pkg

// ---- p6mux_rx_pick.sv ----
// Signal picker for one receive port
`timescale 1ns/1ps
`default_nettype none
module p6mux_rx_pick (
    input wire logic [2:0] sel,
    input wire logic [3:0] remote_pin,
    input wire logic lock,
    input wire logic pass,
    input wire logic frame_valid,
    input wire logic line_valid,
    output logic picked
);
    always_comb begin
        case (sel)
            3'h0: picked = remote_pin[0]; // (R3)
            3'h1: picked = remote_pin[1];
            3'h2: picked = remote_pin[2];
            3'h3: picked = remote_pin[3];
            3'h4: picked = lock; // (R4)
            3'h5: picked = pass; // (R4)
            3'h6: picked = frame_valid; // (R5)
            3'h7: picked = line_valid; // (R5)
            default: picked = 1'b0;
        endcase
    end
endmodule : p6mux_rx_pick
`default_nettype wire

// ---- p6mux_top.sv ----
// Pin 6 output multiplexer, drive control and its APB register slave
//
// Contract
// (R1) Source codes 000 to 011 route receive ports 0 to 3 to the picker.
// (R2) Source 100 picks device status, 110 the transmit group; 101, 111 reserved.
// (R3) Select field bits 7:5 picks the signal; receive select 000 is remote pin 0.
// (R4) Receive select 100 drives port lock, 101 port pass.
// (R5) Receive select 110 drives port frame valid, 111 port line valid.
// (R6) Device status select 000 drives the local level bit.
// (R7) Device status 001 is OR of enabled locks, 010 their AND.
// (R8) Device status 011 is AND of enabled port pass indications.
// (R9) Device status 100 drives frame sync; 101 to 111 reserved.
// (R10) Transmit select 000 is AND of selected pass, 001 their OR.
// (R11) Transmit 010 drives sending-frame level, 011 sending-line level.
// (R12) Transmit 100 is data synchronised, 101 transmit interrupt; 111 reserved.
// (R13) Bit 0 enables the pin driver; bit 1 is the local level.
// (R14) Control register at index 0x16 resets to 0x00.
// (R15) With enable clear the pin is never driven.
// (R16) Reserved codes drive the pin low while enabled.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "p6mux_cfg.svh"
module p6mux_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`P6M_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] rx_remote_pin,
    input wire logic [3:0] rx_lock,
    input wire logic [3:0] rx_pass,
    input wire logic [3:0] rx_frame_valid,
    input wire logic [3:0] rx_line_valid,
    input wire logic frame_sync_pulse,
    input wire logic tx_frame_valid,
    input wire logic tx_line_valid,
    input wire logic tx_synced,
    input wire logic tx_irq,
    output logic pin6_out,
    output logic pin6_oe
);
    import p6mux_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [7:0] word_idx;
    logic hit_ctl;
    logic hit_cfg;
    logic hit_sts;
    logic hit_any;

    // Low two address bits are ignored: every register is one aligned word
    assign word_idx = paddr[`P6M_ADDR_W-1:2];
    assign hit_ctl = (word_idx == `P6M_IDX_OUT_CTL);
    assign hit_cfg = (word_idx == `P6M_IDX_PORT_CFG);
    assign hit_sts = (word_idx == `P6M_IDX_STATUS);
    assign hit_any = hit_ctl | hit_cfg | hit_sts;

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    p6m_bus_t bus_ff;
    p6m_bus_t nxt_bus;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic wr_take;
    logic [31:0] rd_word;

    // Write lands only at the edge where the master sees pready
    // A write without the low byte strobe is dropped, never merged
    assign wr_take = psel & penable & pready_ff & pwrite & pstrb[0];

    always_comb begin
        nxt_bus = bus_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        case (bus_ff)
            P6M_BUS_IDLE: begin
                if (psel & ~penable) begin
                    nxt_bus = P6M_BUS_ANSWER;
                    nxt_pready = 1'b1;
                    nxt_pslverr = ~hit_any;
                    nxt_prdata = 32'h0000_0000;
                    if (~pwrite) begin
                        nxt_prdata = rd_word;
                    end
                end
            end
            P6M_BUS_ANSWER: begin
                // Access edge: answer was up for exactly one cycle
                nxt_bus = P6M_BUS_IDLE;
            end
            default: begin
                nxt_bus = P6M_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ff <= P6M_BUS_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            bus_ff <= nxt_bus;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;

    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_cfg = cfg_ff;
        if (wr_take & hit_ctl) begin
            nxt_ctl = pwdata[7:0];
        end
        if (wr_take & hit_cfg) begin
            nxt_cfg = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= `P6M_OUT_CTL_RST; // (R14)
            cfg_ff <= `P6M_PORT_CFG_RST;
        end else begin
            ctl_ff <= nxt_ctl;
            cfg_ff <= nxt_cfg;
        end
    end

    // ****************************************************************
    // Field views
    // ****************************************************************
    logic pin6_drive_enable;
    logic pin6_local_level;
    p6m_src_t pin6_source_group;
    logic [2:0] pin6_signal_select;
    logic [3:0] port_enabled;
    logic [3:0] tx_port_chosen;

    assign pin6_drive_enable = ctl_ff[`P6M_EN_BIT]; // (R13)
    assign pin6_local_level = ctl_ff[`P6M_VAL_BIT]; // (R13)
    assign pin6_source_group = p6m_src_t'(ctl_ff[`P6M_SRC_HI:`P6M_SRC_LO]); // (R1)
    assign pin6_signal_select = ctl_ff[`P6M_SEL_HI:`P6M_SEL_LO]; // (R3)
    assign port_enabled = cfg_ff[`P6M_PEN_HI:`P6M_PEN_LO];
    assign tx_port_chosen = cfg_ff[`P6M_TXS_HI:`P6M_TXS_LO];

    // ****************************************************************
    // Per-port pickers
    // ****************************************************************
    logic [3:0] rx_picked;

    genvar gp;
    generate
        for (gp = 0; gp < 4; gp = gp + 1) begin : g_rx
            p6mux_rx_pick i_p6mux_rx_pick (
                .sel(pin6_signal_select),
                .remote_pin(rx_remote_pin[gp*4 +: 4]),
                .lock(rx_lock[gp]),
                .pass(rx_pass[gp]),
                .frame_valid(rx_frame_valid[gp]),
                .line_valid(rx_line_valid[gp]),
                .picked(rx_picked[gp])
            );
        end
    endgenerate

    // ****************************************************************
    // Group status terms
    // ****************************************************************
    logic lock_or_en;
    logic lock_and_en;
    logic pass_and_en;
    logic pass_and_tx;
    logic pass_or_tx;

    // An empty port set yields low for AND as well as OR, never a false good
    assign lock_or_en = |(rx_lock & port_enabled); // (R7)
    assign lock_and_en = (|port_enabled) & (&(rx_lock | ~port_enabled)); // (R7)
    assign pass_and_en = (|port_enabled) & (&(rx_pass | ~port_enabled)); // (R8)
    assign pass_and_tx = (|tx_port_chosen) & (&(rx_pass | ~tx_port_chosen)); // (R10)
    assign pass_or_tx = |(rx_pass & tx_port_chosen); // (R10)

    // ****************************************************************
    // Output selection
    // ****************************************************************
    logic dev_pick;
    logic tx_pick;
    logic mux_val;

    always_comb begin
        case (pin6_signal_select)
            3'h0: dev_pick = pin6_local_level; // (R6)
            3'h1: dev_pick = lock_or_en; // (R7)
            3'h2: dev_pick = lock_and_en; // (R7)
            3'h3: dev_pick = pass_and_en; // (R8)
            3'h4: dev_pick = frame_sync_pulse; // (R9)
            default: dev_pick = 1'b0; // (R16)
        endcase
    end

    always_comb begin
        case (pin6_signal_select)
            3'h0: tx_pick = pass_and_tx; // (R10)
            3'h1: tx_pick = pass_or_tx; // (R10)
            3'h2: tx_pick = tx_frame_valid; // (R11)
            3'h3: tx_pick = tx_line_valid; // (R11)
            3'h4: tx_pick = tx_synced; // (R12)
            3'h5: tx_pick = tx_irq; // (R12)
            default: tx_pick = 1'b0; // (R16)
        endcase
    end

    always_comb begin
        case (pin6_source_group)
            P6M_SRC_RX0: mux_val = rx_picked[0]; // (R1)
            P6M_SRC_RX1: mux_val = rx_picked[1]; // (R1)
            P6M_SRC_RX2: mux_val = rx_picked[2]; // (R1)
            P6M_SRC_RX3: mux_val = rx_picked[3]; // (R1)
            P6M_SRC_DEV: mux_val = dev_pick; // (R2)
            P6M_SRC_TX0: mux_val = tx_pick; // (R2)
            default: mux_val = 1'b0; // (R16)
        endcase
    end

    // ****************************************************************
    // Pin driver
    // ****************************************************************
    logic pin_out_ff;
    logic nxt_pin_out;
    logic pin_oe_ff;
    logic nxt_pin_oe;

    // Data is forced low while disabled so no stale level leaks on re-enable
    // One cycle of latency from any source to the pin, traded for clean outputs
    always_comb begin
        nxt_pin_oe = pin6_drive_enable; // (R13)
        nxt_pin_out = pin6_drive_enable & mux_val; // (R15)
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0; // (R15)
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end

    assign pin6_out = pin_out_ff;
    assign pin6_oe = pin_oe_ff;

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] sts_byte;

    // Status shows the live mux value and the registered pin state
    // Unmapped words read zero; the slave flags them through pslverr
    assign sts_byte = {5'h00, mux_val, pin_oe_ff, pin_out_ff};

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctl) begin
            rd_word = {24'h00_0000, ctl_ff};
        end else if (hit_cfg) begin
            rd_word = {24'h00_0000, cfg_ff};
        end else if (hit_sts) begin
            rd_word = {24'h00_0000, sts_byte};
        end
    end

endmodule : p6mux_top
`default_nettype wire

// ---- p6mux_assertions.sv ----
// Checker of the pin 6 mux port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "p6mux_cfg.svh"
module p6mux_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`P6M_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [15:0] rx_remote_pin,
    input wire logic [3:0] rx_lock,
    input wire logic frame_sync_pulse,
    input wire logic tx_irq,
    input wire logic pin6_out,
    input wire logic pin6_oe
);
    // ****
    // Shadow of the control register, seen only through the bus
    // ****
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic [2:0] src;
    logic [2:0] sel;
    logic en;
    assign src = ctl_ff[4:2];
    assign sel = ctl_ff[7:5];
    assign en = ctl_ff[0];
    always_comb begin
        nxt_ctl = ctl_ff;
        if (psel && penable && pready && pwrite && pstrb[0]
            && paddr[`P6M_ADDR_W-1:2] == `P6M_IDX_OUT_CTL) begin
            nxt_ctl = pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 8'h00;
        end else begin
            ctl_ff <= nxt_ctl;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_EN_DRIVES: assert property (en |=> pin6_oe)
        else $error("driver not enabled");
    AST_DIS_RELEASE: assert property (!en |=> !pin6_oe && !pin6_out)
        else $error("pin driven while disabled");
    AST_RX_REMOTE: assert property (en && !src[2] && !sel[2] |=>
        pin6_out == $past(rx_remote_pin[{src[1:0], sel[1:0]}])) else $error("remote pin wrong");
    AST_RX_LOCK: assert property (en && !src[2] && sel == 3'h4 |=>
        pin6_out == $past(rx_lock[src[1:0]])) else $error("port lock wrong");
    AST_DEV_LOCAL: assert property (en && src == 3'h4 && sel == 3'h0 |=>
        pin6_out == $past(ctl_ff[1])) else $error("local level wrong");
    AST_FSYNC: assert property (en && src == 3'h4 && sel == 3'h4 |=>
        pin6_out == $past(frame_sync_pulse)) else $error("frame sync wrong");
    AST_TX_IRQ: assert property (en && src == 3'h6 && sel == 3'h5 |=>
        pin6_out == $past(tx_irq)) else $error("transmit interrupt wrong");
    AST_RSV_SRC: assert property (en && src[2] && src[0] |=> pin6_oe && !pin6_out)
        else $error("reserved source not low");
    cover property (en && src == 3'h6 && sel == 3'h1);
    cover property (en && src == 3'h4 && sel == 3'h2);
    cover property (psel && penable && pready && pwrite);
endmodule : p6mux_assertions
bind p6mux_top p6mux_assertions i_p6mux_assertions (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .rx_remote_pin(rx_remote_pin), .rx_lock(rx_lock),
    .frame_sync_pulse(frame_sync_pulse), .tx_irq(tx_irq), .pin6_out(pin6_out),
    .pin6_oe(pin6_oe));
`default_nettype wire

// ---- p6mux_pin_model.sv ----
// Board-side model that resolves the level seen on pin 6
`timescale 1ns/1ps
`default_nettype none
module p6mux_pin_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin6_out,
    input wire logic pin6_oe,
    output logic pin_level
);
    logic last_ff;
    logic nxt_last;
    // No pull on the pin, so a released line shows the inverse of its last level
    always_comb begin
        nxt_last = pin6_oe ? pin6_out : last_ff;
        pin_level = pin6_oe ? pin6_out : ~last_ff;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= nxt_last;
        end
    end
endmodule : p6mux_pin_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the pin 6 output mux
`timescale 1ns/1ps
`default_nettype none
`include "p6mux_cfg.svh"
module tb_top;
    import p6mux_pkg::*;
    localparam logic [`P6M_ADDR_W-1:0] A_CTL = {`P6M_IDX_OUT_CTL, 2'b00};
    localparam logic [`P6M_ADDR_W-1:0] A_CFG = {`P6M_IDX_PORT_CFG, 2'b00};
    localparam logic [`P6M_ADDR_W-1:0] A_STS = {`P6M_IDX_STATUS, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin6_out, pin6_oe;
    logic pin_level, er, frame_sync_pulse, tx_frame_valid, tx_line_valid, tx_synced, tx_irq;
    logic [`P6M_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, rx_lock, rx_pass, rx_frame_valid, rx_line_valid;
    logic [15:0] rx_remote_pin;
    logic [7:0] cfg;
    logic [36:0] pats [4] = '{37'h0, 37'h1fffffffff, 37'h0a5c3a9e35, 37'h15a3c561ca};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    p6mux_top i_p6mux_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_remote_pin(rx_remote_pin), .rx_lock(rx_lock),
        .rx_pass(rx_pass), .rx_frame_valid(rx_frame_valid), .rx_line_valid(rx_line_valid),
        .frame_sync_pulse(frame_sync_pulse), .tx_frame_valid(tx_frame_valid),
        .tx_line_valid(tx_line_valid), .tx_synced(tx_synced), .tx_irq(tx_irq),
        .pin6_out(pin6_out), .pin6_oe(pin6_oe));
    p6mux_pin_model i_p6mux_pin_model (.pclk(pclk), .presetn(presetn), .pin6_out(pin6_out),
        .pin6_oe(pin6_oe), .pin_level(pin_level));
    // ****
    // Expected pin level; empty port sets give 0 for AND and OR
    // ****
    function automatic logic exp_pin(input logic [7:0] c);
        logic [1:0] p;
        logic [3:0] pe;
        logic [3:0] ts;
        p = c[3:2];
        pe = cfg[3:0];
        ts = cfg[7:4];
        if (!c[0]) return 1'b0;
        case (p6m_src_t'(c[4:2]))
            P6M_SRC_RX0, P6M_SRC_RX1, P6M_SRC_RX2, P6M_SRC_RX3: begin
                case (c[7:5])
                    3'h4: return rx_lock[p];
                    3'h5: return rx_pass[p];
                    3'h6: return rx_frame_valid[p];
                    3'h7: return rx_line_valid[p];
                    default: return rx_remote_pin[{p, c[6:5]}];
                endcase
            end
            P6M_SRC_DEV: begin
                case (c[7:5])
                    3'h0: return c[1];
                    3'h1: return |(rx_lock & pe);
                    3'h2: return pe != 4'h0 && &(rx_lock | ~pe);
                    3'h3: return pe != 4'h0 && &(rx_pass | ~pe);
                    3'h4: return frame_sync_pulse;
                    default: return 1'b0;
                endcase
            end
            P6M_SRC_TX0: begin
                case (c[7:5])
                    3'h0: return ts != 4'h0 && &(rx_pass | ~ts);
                    3'h1: return |(rx_pass & ts);
                    3'h2: return tx_frame_valid;
                    3'h3: return tx_line_valid;
                    3'h4: return tx_synced;
                    3'h5: return tx_irq;
                    default: return 1'b0;
                endcase
            end
            default: return 1'b0;
        endcase
    endfunction : exp_pin
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Request holds until pready is seen high at a rising edge; data taken at that edge
    task automatic apb(input logic w, input logic [`P6M_ADDR_W-1:0] a, input logic [7:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic t_reset;
        apb(1'b0, A_CTL, 8'h00, rd, er);
        chk(rd, 32'h0, "control reset");
        chk({31'h0, pin6_oe}, 32'h0, "enable reset");
    endtask : t_reset
    task automatic t_sweep;
        apb(1'b1, A_CFG, 8'h6a, rd, er);
        cfg = 8'h6a;
        for (int c = 0; c < 256; c++) begin
            apb(1'b1, A_CTL, c[7:0], rd, er);
            apb(1'b0, A_CTL, 8'h00, rd, er);
            chk(rd, {24'h0, c[7:0]}, "control readback");
            for (int j = 0; j < 4; j++) begin
                @(posedge pclk);
                {rx_remote_pin, rx_lock, rx_pass, rx_frame_valid, rx_line_valid,
                    frame_sync_pulse, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} <= pats[j];
                @(posedge pclk);
                @(negedge pclk);
                chk({31'h0, pin6_oe}, {31'h0, c[0]}, "drive enable");
                chk({31'h0, pin6_oe ? pin_level : 1'b0}, {31'h0, exp_pin(c[7:0])}, "pin");
            end
        end
    endtask : t_sweep
    task automatic t_status;
        apb(1'b0, A_STS, 8'h00, rd, er);
        chk(rd, 32'h2, "status word");
        apb(1'b0, A_CFG, 8'h00, rd, er);
        chk(rd, 32'h6a, "port config readback");
        pstrb <= 4'he;
        apb(1'b1, A_CTL, 8'h00, rd, er);
        pstrb <= 4'hf;
        apb(1'b0, A_CTL, 8'h00, rd, er);
        chk(rd, 32'hff, "strobe-less write dropped");
    endtask : t_status
    task automatic t_unmapped;
        apb(1'b0, 10'h3fc, 8'h00, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, 10'h3fc, 8'h55, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped write error");
    endtask : t_unmapped
    task automatic t_midreset;
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({31'h0, pin6_oe}, 32'h0, "enable in reset");
        chk({31'h0, pin6_out}, 32'h0, "data in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
    endtask : t_midreset
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Limit well above the full sweep
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cfg} = '0;
        pstrb = 4'hf;
        {rx_remote_pin, rx_lock, rx_pass, rx_frame_valid, rx_line_valid,
            frame_sync_pulse, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sweep();
        t_status();
        t_unmapped();
        t_midreset();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
